/* design/output_rate_decimator.sv */
`timescale 1ns/1ps
module output_rate_decimator
  import rate_decimator_pkg::*;
#(
  parameter int unsigned cnt_width = rate_decimator_pkg::cnt_w
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // converter side
  input wire logic word_ready_n,
  output rate_decimator_pkg::select_drive_s chip_select,
  // board straps
  input wire logic [rate_decimator_pkg::sel_w-1:0] rate_select_header,
  input wire rate_decimator_pkg::route_e select_route_jumper,
  // observation
  output logic [cnt_width-1:0] pulse_count,
  output logic counter_route_position
);
  import rate_decimator_pkg::*;

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  // the top terminal count needs cnt_w bits; a narrower counter wraps
  if (cnt_width < cnt_w) begin
    $error("cnt_width too small for the top terminal count");
  end

  // the package width must itself hold two to the top setting plus one
  if (cnt_w < int'(max_setting) + 2) begin
    $error("package counter width below the top setting");
  end

  // ----------------------------------------
  // shared decodes
  // ----------------------------------------
  // straps above the top setting act as the top setting
  function automatic logic [sel_w-1:0] clamp_setting(
    input logic [sel_w-1:0] n
  );
    if (n > max_setting) begin
      clamp_setting = max_setting;
    end else begin
      clamp_setting = n;
    end
  endfunction

  // the hold flop releases select on the first ready rise after arming
  function automatic logic clear_due(
    input logic hold,
    input logic rise
  );
    clear_due = hold && rise;
  endfunction

  function automatic logic routed(
    input route_e route
  );
    unique case (route)
      route_counter: routed = 1'b1;
      route_open: routed = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // ready synchroniser and edge detect
  // ----------------------------------------
  logic ready_s1_q;
  logic ready_s2_q;
  logic ready_s3_q;
  logic ready_fall;
  logic ready_rise;

  // resets high: ready is idle high, avoids a false edge at release
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ready_s1_q <= 1'b1;
      ready_s2_q <= 1'b1;
      ready_s3_q <= 1'b1;
    end else begin
      ready_s1_q <= word_ready_n;
      ready_s2_q <= ready_s1_q;
      ready_s3_q <= ready_s2_q;
    end
  end

  assign ready_fall = ready_s3_q & ~ready_s2_q;
  assign ready_rise = ~ready_s3_q & ready_s2_q;

  // ----------------------------------------
  // terminal count select
  // ----------------------------------------
  function automatic logic [cnt_width-1:0] terminal(
    input logic [sel_w-1:0] n
  );
    logic [sel_w-1:0] m;
    m = clamp_setting(n);
    terminal = cnt_width'(cnt_one) << (m + 4'h1);
  endfunction

  logic [cnt_width-1:0] term_count;
  logic reached;
  assign term_count = terminal(rate_select_header);

  // ----------------------------------------
  // pulse counter and hold flop
  // ----------------------------------------
  logic [cnt_width-1:0] pulse_counter_q;
  logic select_hold_flop_q;
  logic clear_now;
  logic select_n_q;
  logic select_oe_q;

  assign reached = (pulse_counter_q == term_count);
  assign clear_now = clear_due(select_hold_flop_q, ready_rise);

  // falls that land while the count sits at terminal are dropped, so a
  // slow read of the word never shortens the next decimation period

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pulse_counter_q <= cnt_width'(cnt_reset);
    end else if (clear_now) begin
      pulse_counter_q <= cnt_width'(cnt_reset);
    end else if (ready_fall && !reached) begin
      pulse_counter_q <= pulse_counter_q + cnt_width'(cnt_one);
    end
  end

  // hold is armed while select is low; the next ready rise clears it
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      select_hold_flop_q <= 1'b0;
    end else if (clear_now) begin
      select_hold_flop_q <= 1'b0;
    end else if (reached) begin
      select_hold_flop_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // chip select drive
  // ----------------------------------------
  // select drops one edge after terminal and rises on the clearing edge
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      select_n_q <= 1'b1;
    end else begin
      select_n_q <= ~(reached && !clear_now);
    end
  end

  // off the counter route the pin is left to outside control
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      select_oe_q <= 1'b0;
    end else begin
      select_oe_q <= routed(select_route_jumper);
    end
  end

  assign chip_select = '{select_n: select_n_q, select_oe: select_oe_q};

  // ----------------------------------------
  // observation outputs
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      counter_route_position <= 1'b0;
    end else begin
      counter_route_position <= routed(select_route_jumper);
    end
  end

  // one cycle behind the counter, in step with select
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pulse_count <= cnt_width'(cnt_reset);
    end else begin
      pulse_count <= pulse_counter_q;
    end
  end

endmodule

/* design/rate_decimator_pkg.sv */
// What this block does
// - count ready pulses to two pow setting+1
// - drive select only in counter route position
// - hold flop input high when select asserts
// - ready rising clears hold, clears counter
// - resume counting from zero after clear
package rate_decimator_pkg;
  localparam int unsigned cnt_w = 13;
  localparam int unsigned sel_w = 4;
  localparam logic [sel_w-1:0] max_setting = 4'hb;
  localparam logic [cnt_w-1:0] cnt_reset = 13'h0000;
  localparam logic [cnt_w-1:0] cnt_one = 13'h0001;

  typedef enum logic {route_open, route_counter} route_e;

  typedef struct packed {
    logic select_n;
    logic select_oe;
  } select_drive_s;
endpackage

/* verification/adc_port_model.sv */
`timescale 1ns/1ps
module adc_port_model #(parameter int word_bits = 16) (
  input wire logic clk,
  input wire logic [7:0] gap,
  input wire logic sel_n,
  output logic ready_n
);
  int t = 0;
  int sh = 0;
  initial ready_n = 1'b1;
  // ready falls only once the previous word was read out or dropped
  always @(negedge clk) begin
    t <= t + 1;
    if (ready_n && t >= int'(gap)) begin
      ready_n <= 1'b0;
      t <= 0;
      sh <= 0;
    end else if (!ready_n && !sel_n && sh < word_bits) begin
      sh <= sh + 1;
    end else if (!ready_n && (sh >= word_bits || (sel_n && t >= 10))) begin
      ready_n <= 1'b1;
      t <= 0;
    end
  end
endmodule

/* verification/decim_props.sv */
`timescale 1ns/1ps
module decim_props import rate_decimator_pkg::*; #(
  parameter int unsigned cnt_width = 13
) (
  input wire logic core_clk, rst_b, word_ready_n,
  input select_drive_s chip_select,
  input wire logic [3:0] rate_select_header,
  input route_e select_route_jumper,
  input wire logic [cnt_width-1:0] pulse_count,
  input wire logic counter_route_position
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [3:0] n;
  // settings above the top one behave as the top one
  assign n = rate_select_header > 4'hb ? 4'hb : rate_select_header;
  sequence rel_s; $rose(word_ready_n) && !chip_select.select_n; endsequence
  a_count_cap: assert property (
    pulse_count <= (cnt_width'(2) << n)) else $error("count too high");
  a_select_term: assert property (
    !chip_select.select_n |-> pulse_count == (cnt_width'(2) << n))
    else $error("select before terminal");
  a_route_oe: assert property (
    1 |=> chip_select.select_oe == $past(select_route_jumper))
    else $error("enable off route");
  a_route_flag: assert property (
    1 |=> counter_route_position == $past(select_route_jumper))
    else $error("route flag wrong");
  a_hold_clear: assert property (
    rel_s |-> ##[1:6] chip_select.select_n) else $error("select stuck");
  a_resume_zero: assert property (
    $rose(chip_select.select_n) |=> pulse_count == 0)
    else $error("count not cleared");
  a_step_one: assert property (
    $changed(pulse_count) |-> pulse_count == $past(pulse_count) + 1
    || pulse_count == 0) else $error("count jumped");
endmodule
bind output_rate_decimator decim_props #(.cnt_width(cnt_width)) u_props (
  .core_clk, .rst_b, .word_ready_n, .chip_select, .rate_select_header,
  .select_route_jumper, .pulse_count, .counter_route_position);

/* verification/test_output_rate_decimator.sv */
`timescale 1ns/1ps
module test_output_rate_decimator;
  import rate_decimator_pkg::*;
  logic core_clk = 0, rst_b = 0, crp, rdy_n, pr = 1, ps = 1, pz = 0;
  logic adc_sel_n;
  logic [3:0] hdr = 4'h0;
  logic [7:0] gap = 8'h8;
  logic [12:0] pc;
  logic [31:0] lf = 32'h9ae6bb12;
  route_e rt = route_counter;
  select_drive_s cs;
  int err_total = 0, tests_run = 0, cnt = 0, sel_seen = 0;
  initial forever #12.5 core_clk = ~core_clk;
  assign adc_sel_n = cs.select_oe ? cs.select_n : rdy_n;
  adc_port_model adc (.clk(core_clk), .gap(gap), .sel_n(adc_sel_n),
    .ready_n(rdy_n));
  output_rate_decimator uut (.core_clk(core_clk), .rst_b(rst_b),
    .word_ready_n(rdy_n), .chip_select(cs), .rate_select_header(hdr),
    .select_route_jumper(rt), .pulse_count(pc), .counter_route_position(crp));
  task automatic chk(string nm, logic [12:0] e, logic [12:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic complete_run;
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (!rst_b) begin
      pr <= 1'b1;
      ps <= 1'b1;
      pz <= 1'b0;
      cnt = 0;
    end else begin
      if (pr && !rdy_n) cnt++;
      if (pz) chk("cleared", 13'h0, pc);
      if (ps && !cs.select_n) begin
        chk("count", 13'h2 << hdr, 13'(cnt));
        chk("pulse", 13'h2 << hdr, pc);
        chk("oe", 13'(rt), 13'(cs.select_oe));
        chk("route", 13'(rt), 13'(crp));
        sel_seen++;
      end
      if (!ps && cs.select_n) cnt = 0;
      pz <= !ps && cs.select_n;
      pr <= rdy_n;
      ps <= cs.select_n;
    end
  end
  initial begin
    for (int k = 0; k < 6; k++) begin
      @(negedge core_clk) rst_b = 0;
      lf = lfsr_next(lf);
      hdr = k < 4 ? 4'(k) : {2'h0, lf[1:0]};
      gap = 8'h8 + {4'h0, lf[5:2]};
      rt = k == 5 ? route_open : route_counter;
      repeat (10) @(negedge core_clk);
      rst_b = 1;
      sel_seen = 0;
      for (int i = 0; i < 3000 && sel_seen < 2; i++) @(negedge core_clk);
      chk("selects", 13'h2, 13'(sel_seen));
    end
    complete_run;
  end
  initial begin
    #1000000;
    err_total++;
    complete_run;
  end
endmodule
